// file: hdl/line_frontend_config_control.sv
// Line front end configuration, transmit driver control and data slicer
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "line_frontend_cfg.svh"
module line_frontend_config_control #(
	parameter int AMP_W = 8,
	parameter int CLK_LOSS_CYCLES = `CLK_LOSS_CYC
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Hardware control pins (asynchronous)
	input wire logic hw_mode_pin_in,
	input wire logic impedance_source_pin_in,
	input wire logic tx_float_pin_in,
	input wire logic tx_pattern_pin1_in,
	input wire logic tx_pattern_pin0_in,
	input wire logic monitor_boost_pin_in,
	input wire logic [3:0] pulse_template_pin_in,
	// Monitored clocks (asynchronous)
	input wire logic master_ref_clock_in,
	input wire logic tx_bit_clock_in,
	// Transmit data from the encoder
	input wire logic tx_pos_in,
	input wire logic tx_neg_in,
	// Transmit line driver
	output logic tx_line_pos_out,
	output logic tx_line_neg_out,
	output logic tx_line_oe_n_out,
	output logic tx_powerdown_out,
	// Termination and waveform control
	output logic tx_int_term_out,
	output logic [1:0] tx_term_code_out,
	output logic [3:0] pulse_template_out,
	output logic rx_int_term_out,
	output logic [1:0] rx_term_code_out,
	// Receive front end control
	output logic [1:0] monitor_gain_out,
	output logic equalizer_on_out,
	output logic los_enable_out,
	output logic [4:0] los_level_out,
	// Receive amplitude samples, one per pulse interval
	input wire logic rx_sample_vld_in,
	input wire logic rx_sample_neg_in,
	input wire logic [AMP_W-1:0] rx_amp_in,
	input wire logic [AMP_W-1:0] rx_peak_in,
	// Slicer output to clock recovery and to the rails
	output logic cdr_pos_out,
	output logic cdr_neg_out,
	output logic cdr_vld_out,
	output logic rx_pos_rail_out,
	output logic rx_neg_rail_out
);
	line_frontend_pkg::ctl_state_t st;
	line_frontend_pkg::ctl_state_t next_st;
	line_frontend_pkg::ctl_pins_t pins_raw;
	logic mclk_lost;
	logic tx_bit_clock_lost;

	initial begin
		if (AMP_W < 2 || AMP_W > 24) begin
			$error("line_frontend_config_control: AMP_W out of range");
		end
	end

	// Impedance code implied by a template code in pin mode
	function automatic logic [1:0] term_from_tmpl(input logic [3:0] t);
		case (t)
			4'h0: term_from_tmpl = 2'h0;
			4'h1: term_from_tmpl = 2'h1;
			4'h7: term_from_tmpl = 2'h3;
			default: term_from_tmpl = 2'h2;
		endcase
	endfunction

	// Slicer decision: nonzero amplitude at or above the chosen fraction of peak
	function automatic logic decision_threshold_sel_hit(input logic [AMP_W-1:0] amp,
		input logic [AMP_W-1:0] pk, input logic [1:0] sel);
		logic [AMP_W+3:0] lhs;
		logic [AMP_W+3:0] rhs;
		lhs = (AMP_W+4)'(amp) * (AMP_W+4)'(10);
		rhs = (AMP_W+4)'(pk) * (AMP_W+4)'({2'b01, sel});
		decision_threshold_sel_hit = (lhs >= rhs) && (amp != '0);
	endfunction

	// Register read data
	function automatic logic [31:0] reg_read(input line_frontend_pkg::ctl_state_t s,
		input logic [5:0] idx, input logic ml, input logic tl);
		case (idx)
			`IDX_TERM: reg_read = {26'h0000000, s.term};
			`IDX_TX_CFG0: reg_read = 32'(s.tx_off) << `TX_OFF_BIT;
			`IDX_TX_CFG1: reg_read = (32'(s.float_req) << `TX_FLOAT_BIT) | 32'(s.tmpl);
			`IDX_RX_CFG1: reg_read = (32'(s.eq) << `EQ_ENABLE_BIT) | 32'(s.los_lvl);
			`IDX_RX_CFG2: reg_read = (32'(s.gain_sel) << `GAIN_LSB) | 32'(s.decision_threshold_sel);
			`IDX_MODE: reg_read = 32'(s.mode);
			`IDX_STAT: reg_read = {21'h000000, s.los_en, s.eq_o, s.gain, s.tx_int,
				s.tx_pd, s.tx_oe_n, s.hold, tl, ml, s.p2.hw_mode};
			default: reg_read = 32'h00000000;
		endcase
	endfunction

	function automatic logic idx_mapped(input logic [5:0] idx);
		idx_mapped = (idx == `IDX_TERM) || (idx == `IDX_TX_CFG0) || (idx == `IDX_TX_CFG1)
			|| (idx == `IDX_RX_CFG1) || (idx == `IDX_RX_CFG2) || (idx == `IDX_MODE)
			|| (idx == `IDX_STAT);
	endfunction

	// Loss detectors for the reference and transmit clocks
	clk_activity_monitor #(.TIMEOUT(CLK_LOSS_CYCLES)) u_mclk_mon (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.probe_in(master_ref_clock_in),
		.lost_out(mclk_lost)
	);
	clk_activity_monitor #(.TIMEOUT(CLK_LOSS_CYCLES)) u_tx_bit_clock_mon (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.probe_in(tx_bit_clock_in),
		.lost_out(tx_bit_clock_lost)
	);

	// Gather the pins so they cross into the clock domain as one bundle
	always_comb begin
		pins_raw.hw_mode = hw_mode_pin_in;
		pins_raw.imp_src = impedance_source_pin_in;
		pins_raw.tx_float = tx_float_pin_in;
		pins_raw.tx_pattern_pin1 = tx_pattern_pin1_in;
		pins_raw.tx_pattern_pin0 = tx_pattern_pin0_in;
		pins_raw.mon_boost = monitor_boost_pin_in;
		pins_raw.tmpl = pulse_template_pin_in;
	end

	// Next state: bus access, configuration, derived controls and slicer
	always_comb begin
		logic [5:0] idx;
		logic wr;
		logic hw;
		logic ext;
		logic fl;
		logic hit;
		idx = paddr_in[7:2];
		wr = psel_in && penable_in && st.pready && pwrite_in;
		hw = st.p2.hw_mode;
		ext = 1'b0;
		fl = 1'b0;
		hit = 1'b0;
		next_st = st;
		next_st.p1 = pins_raw;
		next_st.p2 = st.p1;

		// APB: ready in the first access cycle, data latched from setup
		next_st.pready = psel_in && !penable_in;
		next_st.pslverr = psel_in && !penable_in && !idx_mapped(idx);
		next_st.prdata = (psel_in && !penable_in && !pwrite_in)
			? reg_read(st, idx, mclk_lost, tx_bit_clock_lost) : 32'h00000000;

		// Register writes take effect only at the completing edge
		if (wr) begin
			case (idx)
				`IDX_TERM: next_st.term = pwdata_in[5:0];
				`IDX_TX_CFG0: begin
					next_st.tx_off = pwdata_in[`TX_OFF_BIT];
					next_st.hold = 1'b0;
				end
				`IDX_TX_CFG1: begin
					next_st.float_req = pwdata_in[`TX_FLOAT_BIT];
					next_st.tmpl = pwdata_in[3:0];
					next_st.hold = 1'b0;
				end
				`IDX_RX_CFG1: begin
					next_st.eq = pwdata_in[`EQ_ENABLE_BIT];
					next_st.los_lvl = pwdata_in[4:0];
				end
				`IDX_RX_CFG2: begin
					next_st.gain_sel = pwdata_in[`GAIN_LSB +: 2];
					next_st.decision_threshold_sel = pwdata_in[`THRESH_LSB +: 2];
				end
				`IDX_MODE: next_st.mode = pwdata_in[3:0];
				default: next_st.hold = st.hold;
			endcase
			// Software reset restores defaults and floats the driver again
			if (idx == `IDX_MODE && pwdata_in[`MODE_SWRST_BIT]) begin
				next_st.term = `TERM_RST;
				next_st.tx_off = `TX_CFG0_RST;
				next_st.float_req = 1'b0;
				next_st.tmpl = `TX_CFG1_RST;
				next_st.eq = 1'b0;
				next_st.los_lvl = `RX_CFG1_RST;
				next_st.gain_sel = 2'h0;
				next_st.decision_threshold_sel = 2'h0;
				next_st.mode = `MODE_RST;
				next_st.hold = 1'b1;
			end
		end
		// Pin mode has no software to release the reset float
		if (hw) begin
			next_st.hold = 1'b0;
		end

		// Termination and template selection
		if (hw) begin
			next_st.tx_int = st.p2.imp_src;
			next_st.rx_int = st.p2.imp_src;
			next_st.tx_ohm = term_from_tmpl(st.p2.tmpl);
			next_st.rx_ohm = term_from_tmpl(st.p2.tmpl);
			next_st.tmpl_o = st.p2.imp_src ? st.p2.tmpl : 4'h1;
			next_st.tx_pd = st.p2.tx_pattern_pin1 && st.p2.tx_pattern_pin0;
			next_st.gain = st.p2.mon_boost ? 2'h2 : 2'h0;
			next_st.eq_o = 1'b0;
			fl = st.p2.tx_float;
		end else begin
			// Outside E1 the external bit is ignored and internal stays on
			ext = st.term[`TERM_TX_LSB + 2] && st.mode[`MODE_E1_BIT];
			next_st.tx_int = !ext;
			next_st.tx_ohm = st.term[`TERM_TX_LSB +: 2];
			next_st.tmpl_o = ext ? 4'h1 : st.tmpl;
			next_st.rx_int = !st.term[`TERM_RX_LSB + 2];
			next_st.rx_ohm = st.term[`TERM_RX_LSB +: 2];
			next_st.tx_pd = st.tx_off;
			next_st.gain = st.gain_sel;
			next_st.eq_o = st.eq;
			fl = st.float_req;
		end
		next_st.los_en = (next_st.gain == 2'h0);
		// Low programmed levels only make sense with the equalizer running
		next_st.los_o = next_st.eq_o ? st.los_lvl : 5'h00;

		// Driver float: any one cause is enough
		fl = fl || next_st.tx_pd || mclk_lost || st.hold
			|| (tx_bit_clock_lost && !st.mode[`MODE_RLOOP_BIT] && !st.mode[`MODE_INTPAT_BIT]);
		next_st.tx_oe_n = fl;
		next_st.tx_pos = fl ? 1'b0 : tx_pos_in;
		next_st.tx_neg = fl ? 1'b0 : tx_neg_in;

		// Slicer: one symbol per interval, steered by recovery enable
		hit = decision_threshold_sel_hit(rx_amp_in, rx_peak_in, st.decision_threshold_sel);
		next_st.cdr_vld = rx_sample_vld_in && st.mode[`MODE_CDR_BIT];
		if (rx_sample_vld_in) begin
			next_st.cdr_pos = hit && !rx_sample_neg_in;
			next_st.cdr_neg = hit && rx_sample_neg_in;
			if (!st.mode[`MODE_CDR_BIT]) begin
				next_st.rx_pos = hit && !rx_sample_neg_in;
				next_st.rx_neg = hit && rx_sample_neg_in;
			end
		end
		if (st.mode[`MODE_CDR_BIT]) begin
			next_st.rx_pos = 1'b0;
			next_st.rx_neg = 1'b0;
		end
	end

	// State register; driver starts floated and held until configured
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.term <= `TERM_RST;
			st.mode <= `MODE_RST;
			st.hold <= 1'b1;
			st.tx_oe_n <= 1'b1;
			st.tx_int <= 1'b1;
			st.rx_int <= 1'b1;
			st.los_en <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign prdata_out = st.prdata;
	assign pready_out = st.pready;
	assign pslverr_out = st.pslverr;
	assign tx_line_pos_out = st.tx_pos;
	assign tx_line_neg_out = st.tx_neg;
	assign tx_line_oe_n_out = st.tx_oe_n;
	assign tx_powerdown_out = st.tx_pd;
	assign tx_int_term_out = st.tx_int;
	assign tx_term_code_out = st.tx_ohm;
	assign pulse_template_out = st.tmpl_o;
	assign rx_int_term_out = st.rx_int;
	assign rx_term_code_out = st.rx_ohm;
	assign monitor_gain_out = st.gain;
	assign equalizer_on_out = st.eq_o;
	assign los_enable_out = st.los_en;
	assign los_level_out = st.los_o;
	assign cdr_pos_out = st.cdr_pos;
	assign cdr_neg_out = st.cdr_neg;
	assign cdr_vld_out = st.cdr_vld;
	assign rx_pos_rail_out = st.rx_pos;
	assign rx_neg_rail_out = st.rx_neg;

	// Checks on the driven outputs
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_sw_pd;
		!st.p2.hw_mode && st.tx_off;
	endsequence
	property p_tx_pd_float;
		s_sw_pd |=> tx_powerdown_out && tx_line_oe_n_out && !tx_line_pos_out;
	endproperty
	a_tx_pd_float: assert property (p_tx_pd_float)
		else $error("powerdown not floating");
	// Powerdown floats on its own, so the float-only check leaves it out
	property p_float_bit;
		!st.p2.hw_mode && st.float_req && !st.tx_off
			|=> tx_line_oe_n_out && !tx_powerdown_out;
	endproperty
	a_float_bit: assert property (p_float_bit)
		else $error("float bit ignored");
	property p_hw_float;
		st.p2.hw_mode && st.p2.tx_float |=> tx_line_oe_n_out;
	endproperty
	a_hw_float: assert property (p_hw_float)
		else $error("float pin ignored");
	property p_mclk_float;
		mclk_lost |=> tx_line_oe_n_out;
	endproperty
	a_mclk_float: assert property (p_mclk_float)
		else $error("clock loss not floating");
	property p_hw_pd;
		st.p2.hw_mode |=> tx_powerdown_out == ($past(st.p2.tx_pattern_pin1) && $past(st.p2.tx_pattern_pin0));
	endproperty
	a_hw_pd: assert property (p_hw_pd)
		else $error("pattern pin powerdown wrong");
	property p_t1_internal;
		!st.p2.hw_mode && !st.mode[`MODE_E1_BIT] |=> tx_int_term_out;
	endproperty
	a_t1_internal: assert property (p_t1_internal)
		else $error("external term outside E1");
	property p_ext_tmpl;
		!st.p2.hw_mode && st.mode[`MODE_E1_BIT] && st.term[`TERM_TX_LSB + 2]
			|=> !tx_int_term_out && pulse_template_out == 4'h1;
	endproperty
	a_ext_tmpl: assert property (p_ext_tmpl)
		else $error("external template wrong");
	property p_los_mon;
		monitor_gain_out != 2'h0 |-> !los_enable_out;
	endproperty
	a_los_mon: assert property (p_los_mon)
		else $error("LOS enabled with gain");
	property p_hw_eq;
		st.p2.hw_mode ##1 st.p2.hw_mode |-> !equalizer_on_out && los_level_out == 5'h00;
	endproperty
	a_hw_eq: assert property (p_hw_eq)
		else $error("equalizer on in pin mode");
	property p_bypass;
		rx_sample_vld_in && !st.mode[`MODE_CDR_BIT] && rx_amp_in == '0
			|=> !rx_pos_rail_out && !rx_neg_rail_out && !cdr_vld_out;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass output wrong");
endmodule
`default_nettype wire

// file: hdl/line_frontend_cfg.svh
// Constants for the line front end configuration and control block
// Summary of operation
// - Internal tx termination picks 75/100/110/120 ohm
// - External tx termination only allowed in E1
// - Tx impedance and template codes follow table
// - Pin mode: low source pin means external
// - Float control bit tristates both tx outputs
// - Pin mode: high float pin tristates tx
// - Ref clock loss, tx clock loss outside loopback/internal pattern, powerdown, reset also tristate tx
// - Tx powerdown bit powers down and tristates
// - Pin mode: both pattern pins high power down
// - Rx termination code; top bit means external
// - Monitor gain 22, 26 or 32 dB
// - Pin mode: monitor pin gives 0/26 dB
// - No loss-of-signal report with boosted gain
// - Equalizer bit enables equalizer, low LOS levels
// - Sensitivity -10/-20 dB; pin mode no equalizer
// - Slicer threshold 40/50/60/70 percent of peak
// - Slicer feeds recovery, else rails directly
// - One standard mark or space per interval
`ifndef LINE_FRONTEND_CFG_SVH
`define LINE_FRONTEND_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_TERM 6'h03
`define IDX_TX_CFG0 6'h05
`define IDX_TX_CFG1 6'h06
`define IDX_RX_CFG1 6'h0B
`define IDX_RX_CFG2 6'h0C
`define IDX_MODE 6'h10
`define IDX_STAT 6'h11
// Field positions
`define TERM_RX_LSB 0
`define TERM_TX_LSB 3
`define TX_OFF_BIT 4
`define TX_FLOAT_BIT 5
`define EQ_ENABLE_BIT 5
`define THRESH_LSB 0
`define GAIN_LSB 2
`define MODE_E1_BIT 0
`define MODE_CDR_BIT 1
`define MODE_RLOOP_BIT 2
`define MODE_INTPAT_BIT 3
`define MODE_SWRST_BIT 4
// Reset values
`define TERM_RST 6'h00
`define TX_CFG0_RST 1'b0
`define TX_CFG1_RST 4'h0
`define RX_CFG1_RST 5'h00
`define MODE_RST 4'h3
// Timing: a monitored clock is lost after this long without an edge
`define SYS_CLK_NS 8
`define CLK_LOSS_NS 2000
`define CLK_LOSS_CYC ((`CLK_LOSS_NS) / (`SYS_CLK_NS))
`endif

// file: hdl/line_frontend_pkg.sv
// Types shared by the line front end configuration and control block
package line_frontend_pkg;
	// Hardware control pins, sampled as one bundle
	typedef struct packed {
		logic hw_mode;
		logic imp_src;
		logic tx_float;
		logic tx_pattern_pin1;
		logic tx_pattern_pin0;
		logic mon_boost;
		logic [3:0] tmpl;
	} ctl_pins_t;

	// Clock activity monitor state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [15:0] cnt;
		logic armed;
		logic lost;
	} clk_mon_state_t;

	// Whole state of the control block
	typedef struct packed {
		ctl_pins_t p1;
		ctl_pins_t p2;
		logic [5:0] term;
		logic tx_off;
		logic [3:0] tmpl;
		logic float_req;
		logic eq;
		logic [4:0] los_lvl;
		logic [1:0] gain_sel;
		logic [1:0] decision_threshold_sel;
		logic [3:0] mode;
		logic hold;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic tx_pos;
		logic tx_neg;
		logic tx_oe_n;
		logic tx_pd;
		logic tx_int;
		logic [1:0] tx_ohm;
		logic [3:0] tmpl_o;
		logic rx_int;
		logic [1:0] rx_ohm;
		logic [1:0] gain;
		logic eq_o;
		logic los_en;
		logic [4:0] los_o;
		logic rx_pos;
		logic rx_neg;
		logic cdr_pos;
		logic cdr_neg;
		logic cdr_vld;
	} ctl_state_t;
endpackage

// file: hdl/clk_activity_monitor.sv
// Loss detector for a foreign clock sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module clk_activity_monitor #(
	parameter int TIMEOUT = 250
) (
	// System clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Monitored clock, treated as a plain asynchronous level
	input wire logic probe_in,
	// Loss flag
	output logic lost_out
);
	line_frontend_pkg::clk_mon_state_t st;
	line_frontend_pkg::clk_mon_state_t next_st;

	// Counter must hold the timeout and the probe needs two samples per period
	initial begin
		if (TIMEOUT < 2 || TIMEOUT > 65535) begin
			$error("clk_activity_monitor: TIMEOUT out of range");
		end
	end

	// Edge seen on the second and third stage only; first stage feeds nothing else
	always_comb begin
		next_st = st;
		next_st.s1 = probe_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// The first edge after reset may only be the idle pin level arriving
		if (st.s2 != st.s3) begin
			next_st.cnt = 16'h0000;
			next_st.armed = 1'b1;
			next_st.lost = st.armed ? 1'b0 : st.lost;
		end else if (st.cnt == 16'(TIMEOUT - 1)) begin
			next_st.lost = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	// Lost until a second edge shows up, so the driver starts safe
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, cnt: 16'h0000, armed: 1'b0, lost: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign lost_out = st.lost;
endmodule
`default_nettype wire

// file: tb/line_side_model.sv
// Line side model: delivers one received pulse interval per bench request
`timescale 1ns/1ps
`default_nettype none
module line_side_model #(
	parameter int AMP_W = 8
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Request from the bench
	input wire logic req_in,
	input wire logic neg_in,
	input wire logic [AMP_W-1:0] amp_in,
	input wire logic [AMP_W-1:0] peak_in,
	// Sample toward the front end
	output logic vld_out,
	output logic neg_out,
	output logic [AMP_W-1:0] amp_out,
	output logic [AMP_W-1:0] peak_out
);
	// Between strobes the magnitudes keep moving, so a stale sample never looks valid
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			vld_out <= 1'b0;
			neg_out <= 1'b0;
			amp_out <= '0;
			peak_out <= '0;
		end else if (req_in) begin
			vld_out <= 1'b1;
			neg_out <= neg_in;
			amp_out <= amp_in;
			peak_out <= peak_in;
		end else begin
			vld_out <= 1'b0;
			neg_out <= ~neg_out;
			amp_out <= ~amp_out;
			peak_out <= peak_out + 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_line_frontend_config_control.sv
// Self-checking bench for the line front end control block
`timescale 1ns/1ps
`default_nettype none
`include "line_frontend_cfg.svh"
module tb_line_frontend_config_control;
	// Clock, reset and bookkeeping
	logic clk = 1'b0, rst_n = 1'b0, ref_run = 1'b1, tx_run = 1'b1;
	int n_errors = 0, n_tests = 0, cyc = 0;
	int mv[5] = '{3, 3, 7, 11, 15};
	int fl[5] = '{1, 1, 0, 0, 1};
	// Design inputs
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hw = 1'b0, imp_src = 1'b1;
	logic flt = 1'b0, pat1 = 1'b0, pat0 = 1'b0, mon = 1'b0, mref = 1'b0, tx_bit_clock = 1'b0;
	logic txp = 1'b0, txn = 1'b0, req = 1'b0, rneg = 1'b0;
	logic [7:0] paddr = 8'h00, ramp = 8'h00, rpeak = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] tmpl = 4'h0;
	// Design outputs and captured answers
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, lpos, lneg, oe_n, pd, tx_int, rx_int, equalizer_enable, los_en;
	logic svld, sneg, cpos, cneg, cvld, rpos, rnr;
	logic [1:0] tx_code, rx_code, gain;
	logic [3:0] tmpl_o;
	logic [4:0] los_lvl;
	logic [7:0] samp, speak;

	initial begin
		forever #4 clk = ~clk;
	end
	// Foreign clocks, unrelated in phase; stopping one exercises loss detection
	initial begin
		#3;
		forever #12 if (ref_run) mref = ~mref;
	end
	initial begin
		#7;
		forever #20 if (tx_run) tx_bit_clock = ~tx_bit_clock;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	line_side_model #(.AMP_W(8)) u_line_side_model (.sys_clk_in(clk), .rst_n_in(rst_n),
		.req_in(req), .neg_in(rneg), .amp_in(ramp), .peak_in(rpeak), .vld_out(svld),
		.neg_out(sneg), .amp_out(samp), .peak_out(speak));
	// Loss count shortened so a stopped clock is seen within a few dozen cycles
	line_frontend_config_control #(.AMP_W(8), .CLK_LOSS_CYCLES(8)) u_line_frontend_config_control (
		.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .hw_mode_pin_in(hw),
		.impedance_source_pin_in(imp_src), .tx_float_pin_in(flt), .tx_pattern_pin1_in(pat1),
		.tx_pattern_pin0_in(pat0), .monitor_boost_pin_in(mon), .pulse_template_pin_in(tmpl),
		.master_ref_clock_in(mref), .tx_bit_clock_in(tx_bit_clock), .tx_pos_in(txp), .tx_neg_in(txn),
		.tx_line_pos_out(lpos), .tx_line_neg_out(lneg), .tx_line_oe_n_out(oe_n),
		.tx_powerdown_out(pd), .tx_int_term_out(tx_int), .tx_term_code_out(tx_code),
		.pulse_template_out(tmpl_o), .rx_int_term_out(rx_int), .rx_term_code_out(rx_code),
		.monitor_gain_out(gain), .equalizer_on_out(equalizer_enable), .los_enable_out(los_en),
		.los_level_out(los_lvl), .rx_sample_vld_in(svld), .rx_sample_neg_in(sneg),
		.rx_amp_in(samp), .rx_peak_in(speak), .cdr_pos_out(cpos), .cdr_neg_out(cneg),
		.cdr_vld_out(cvld), .rx_pos_rail_out(rpos), .rx_neg_rail_out(rnr));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; the request holds until pready is sampled high
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the hang guard ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wreg(input logic [5:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
		wt(2);
	endtask
	function automatic logic fn_mark(input logic [7:0] a, input logic [7:0] p, input int s);
		return (int'(a) * 10 >= int'(p) * (4 + s)) && (a != 8'h00);
	endfunction
	function automatic logic [1:0] fn_hw_code(input int t);
		return (t == 0) ? 2'b00 : (t == 1) ? 2'b01 : (t == 7) ? 2'b11 : 2'b10;
	endfunction
	// One pulse interval through the line model and the slicer
	task automatic decision_threshold_sel_one(input logic ng, input logic [7:0] a, input logic [7:0] p,
		input int s, input logic cdr);
		logic m;
		m = fn_mark(a, p, s);
		req <= 1'b1;
		rneg <= ng;
		ramp <= a;
		rpeak <= p;
		@(posedge clk);
		req <= 1'b0;
		wt(2);
		check("cdr_pos", 32'(cpos), 32'(m & ~ng));
		check("cdr_neg", 32'(cneg), 32'(m & ng));
		check("rx_pos_rail", 32'(rpos), 32'(~cdr & m & ~ng));
		check("rx_neg_rail", 32'(rnr), 32'(~cdr & m & ng));
		check("cdr_vld", 32'(cvld), 32'(cdr));
		@(posedge clk);
		check("cdr_vld_end", 32'(cvld), 32'h0);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		int r, m4, s2, lv;
		logic x;
		logic [7:0] a, p;
		void'($urandom(23));
		wt(5);
		rst_n <= 1'b1;
		wt(2);
		check("oe_n_reset", 32'(oe_n), 32'h1);
		check("rx_int_reset", 32'(rx_int), 32'h1);
		apb(1'b0, `IDX_MODE, 32'h0);
		check("mode_reset", rd, 32'h3);
		apb(1'b0, 6'h20, 32'h0);
		check("unmapped_err", 32'(err), 32'h1);
		check("unmapped_data", rd, 32'h0);
		wreg(`IDX_TX_CFG0, 32'hFFFF_FFFF);
		apb(1'b0, `IDX_TX_CFG0, 32'h0);
		check("tx_config_0_read", rd, 32'h10);
		check("powerdown", 32'(pd), 32'h1);
		check("oe_n_powerdown", 32'(oe_n), 32'h1);
		wreg(`IDX_TX_CFG0, 32'h0);
		check("oe_n_release", 32'(oe_n), 32'h0);
		$display("test reset and map done");
		for (int e = 0; e < 2; e++) begin
			wreg(`IDX_MODE, 32'(2 + e));
			for (int t = 0; t < 8; t++) begin
				r = $urandom % 8;
				m4 = $urandom % 16;
				wreg(`IDX_TERM, 32'(t * 8 + r));
				wreg(`IDX_TX_CFG1, 32'(m4));
				x = (t >= 4) && (e == 1);
				check("tx_int_term", 32'(tx_int), 32'(!x));
				if (!x) check("tx_term_code", 32'(tx_code), 32'(t % 4));
				check("template", 32'(tmpl_o), x ? 32'h1 : 32'(m4));
				check("rx_int_term", 32'(rx_int), 32'(r < 4));
				check("rx_term_code", 32'(rx_code), 32'(r % 4));
			end
		end
		$display("test termination done");
		txp <= 1'b1;
		txn <= 1'b0;
		wt(4);
		check("line_pos", 32'(lpos), 32'h1);
		check("line_neg", 32'(lneg), 32'h0);
		txn <= 1'b1;
		wt(3);
		check("line_neg_drive", 32'(lneg), 32'h1);
		wreg(`IDX_TX_CFG1, 32'h20);
		check("oe_n_float", 32'(oe_n), 32'h1);
		check("pd_float", 32'(pd), 32'h0);
		check("line_pos_float", 32'(lpos), 32'h0);
		check("line_neg_float", 32'(lneg), 32'h0);
		wreg(`IDX_TX_CFG1, 32'h0);
		for (int k = 0; k < 5; k++) begin
			wreg(`IDX_MODE, 32'(mv[k]));
			ref_run <= (k != 0) && (k != 4);
			tx_run <= (k == 0) || (k == 4);
			wt(20);
			check("oe_n_clock_loss", 32'(oe_n), 32'(fl[k]));
			ref_run <= 1'b1;
			tx_run <= 1'b1;
			wt(20);
			check("oe_n_clock_back", 32'(oe_n), 32'h0);
		end
		$display("test driver float done");
		for (int g = 0; g < 4; g++) begin
			wreg(`IDX_RX_CFG2, 32'(g * 4 + $urandom % 4));
			check("monitor_gain", 32'(gain), 32'(g));
			check("los_enable", 32'(los_en), 32'(g == 0));
			lv = $urandom % 32;
			wreg(`IDX_RX_CFG1, 32'((g % 2) * 32 + lv));
			check("equalizer_on", 32'(equalizer_enable), 32'(g % 2));
			check("los_level", 32'(los_lvl), 32'((g % 2) ? lv : 0));
		end
		for (int i = 0; i < 32; i++) begin
			s2 = i % 4;
			if (i % 16 == 0) wreg(`IDX_MODE, (i == 0) ? 32'h3 : 32'h1);
			wreg(`IDX_RX_CFG2, 32'(s2));
			p = 8'h0A;
			a = 8'(4 + s2 - (i % 2));
			if (i % 8 == 2) a = 8'h00;
			if (i % 8 > 2) a = 8'($urandom);
			if (i % 8 > 2) p = 8'($urandom);
			decision_threshold_sel_one(1'(i / 2), a, p, s2, i < 16);
		end
		$display("test receive done");
		wreg(`IDX_RX_CFG1, 32'h20);
		hw <= 1'b1;
		imp_src <= 1'b0;
		wt(6);
		check("hw_tx_ext", 32'(tx_int), 32'h0);
		check("hw_rx_ext", 32'(rx_int), 32'h0);
		check("hw_equalizer", 32'(equalizer_enable), 32'h0);
		check("hw_ext_template", 32'(tmpl_o), 32'h1);
		for (int j = 0; j < 8; j++) begin
			imp_src <= 1'b1;
			tmpl <= 4'(j);
			flt <= j[0];
			pat1 <= j[1];
			pat0 <= j[2];
			mon <= j[1];
			wt(6);
			check("hw_tx_int", 32'(tx_int), 32'h1);
			check("hw_tx_code", 32'(tx_code), 32'(fn_hw_code(j)));
			check("hw_rx_code", 32'(rx_code), 32'(fn_hw_code(j)));
			check("hw_rx_int", 32'(rx_int), 32'h1);
			check("hw_template", 32'(tmpl_o), 32'(j));
			check("hw_oe_n", 32'(oe_n), 32'(j[0] | (j[1] & j[2])));
			check("hw_pd", 32'(pd), 32'(j[1] & j[2]));
			check("hw_gain", 32'(gain), j[1] ? 32'h2 : 32'h0);
			check("hw_los_en", 32'(los_en), 32'(!j[1]));
		end
		hw <= 1'b0;
		wt(6);
		$display("test pin control done");
		wreg(`IDX_MODE, 32'h13);
		check("oe_n_sw_reset", 32'(oe_n), 32'h1);
		apb(1'b0, `IDX_MODE, 32'h0);
		check("mode_after_sw_reset", rd, 32'h3);
		$display("test software reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
